// ==== cts_pkg.sv ====
// Constants shared by the cascade and tracking sequencer.
// Assumes a single 200 MHz clock domain and a PMBus-style register port.
package cts_pkg;
    // ------------------------------------------------------------
    // Register indices (chosen locally, no offsets printed)
    // ------------------------------------------------------------
    localparam logic [1:0] CTS_REG_TRIM = 2'h0;
    localparam logic [1:0] CTS_REG_OVEN = 2'h1;
    localparam logic [1:0] CTS_REG_UVEN = 2'h2;
    localparam logic [1:0] CTS_REG_CHAN = 2'h3;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTS_TRIM_POL_BIT = 0;
    localparam int CTS_TRIM_GAIN_BIT = 1;
    localparam int CTS_CASCADE_BIT = 8;
    localparam int CTS_TRACK_BIT = 9;
    localparam int CTS_FLRESP_BIT = 10;
    localparam int CTS_CTRL0_POL_BIT = 4;
    localparam int CTS_CTRL1_POL_BIT = 5;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CTS_TRIM_RST = 16'h0008;
    localparam logic [7:0] CTS_EN_RST = 8'h00;
    localparam logic [7:0] CTS_CHAN_RST = 8'h00;
    // Per-channel sequencing states
    typedef enum logic [2:0] {
        CTS_OFF, CTS_DELAY_ON, CTS_RISE, CTS_ON, CTS_DELAY_OFF, CTS_LATCHED
    } cts_state_type;
endpackage

// ==== cts_channel.sv ====
// One channel of the sequencer: on delay, rise, on, off delay, latched off.
// Assumes fault and start inputs already synchronised to clock.
module cts_channel #(
    parameter int CNT_W = 16
) (
    input wire logic clock, // 200 MHz clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic ce, // Clock enable
    input wire logic start, // Start request (polarity resolved)
    input wire logic force_down, // Group or system turn-off
    input wire logic fault, // Channel OV or UV fault
    input wire logic retry_ok, // Retries remain
    input wire logic clear_latch, // Off-then-on clears latched fault
    input wire logic track_en, // Tracking mode
    input wire logic [CNT_W-1:0] ton_delay, // On delay cycles
    input wire logic [CNT_W-1:0] ton_rise, // Rise cycles
    input wire logic [CNT_W-1:0] toff_delay, // Off delay cycles
    output logic enable_out, // Converter enable
    output logic uv_mask, // Ignore UV now
    output logic latched // Latched off
);
    import cts_pkg::*;
    initial begin
        if (CNT_W < 2) $error("CNT_W too small");
    end
    typedef struct packed {
        cts_state_type st;
        logic [CNT_W-1:0] cnt;
    } cts_ch_type;
    cts_ch_type s_r, s_nxt;

    // Sequencing step
    always_comb begin
        s_nxt = s_r;
        unique case (s_r.st)
            CTS_OFF: begin
                if (start && !force_down) begin
                    s_nxt.st = CTS_DELAY_ON;
                    s_nxt.cnt = ton_delay;
                end
            end
            CTS_DELAY_ON: begin
                if (!start || force_down) s_nxt.st = CTS_OFF;
                else if (s_r.cnt == '0) begin
                    s_nxt.st = CTS_RISE;
                    s_nxt.cnt = ton_rise;
                end else s_nxt.cnt = s_r.cnt - 1'b1;
            end
            CTS_RISE, CTS_ON: begin
                if (fault) begin
                    s_nxt.st = retry_ok ? CTS_OFF : CTS_LATCHED;
                end else if (!start || force_down) begin
                    s_nxt.st = CTS_DELAY_OFF;
                    s_nxt.cnt = toff_delay;
                end else if (s_r.st == CTS_RISE) begin
                    if (s_r.cnt == '0) s_nxt.st = CTS_ON;
                    else s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            CTS_DELAY_OFF: begin
                if (s_r.cnt == '0) s_nxt.st = CTS_OFF;
                else s_nxt.cnt = s_r.cnt - 1'b1;
            end
            CTS_LATCHED: begin
                if (clear_latch) s_nxt.st = CTS_OFF;
            end
            default: s_nxt.st = CTS_OFF;
        endcase
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '{st: CTS_OFF, cnt: '0};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Enable stays on through off delay so tracking slaves fall with master
    assign enable_out = (s_r.st == CTS_RISE) || (s_r.st == CTS_ON) || (s_r.st == CTS_DELAY_OFF);
    // RL14 UV masked off-delay
    // RL15 UV masked rising
    assign uv_mask = (s_r.st == CTS_RISE) || (track_en && s_r.st == CTS_DELAY_OFF);
    assign latched = (s_r.st == CTS_LATCHED);
endmodule

// ==== cts_top.sv ====
// Two-channel cascade and tracking sequencer with fault-pin configuration.
// Assumes converters and fault pins are outside the clock domain.
// Operation
// RL1 - Gain bit clear selects 1.38V full scale, set selects 2.65V.
// RL2 - Polarity bit clear means inverting trim, set means non-inverting.
// RL3 - Cascade slave waits for its control input before starting.
// RL4 - Host turns supplies off by operation command or fault pin.
// RL5 - Chain cascade through supply power-good, never general power-good.
// RL6 - Cascade channel keeps retrying faults while control input is low.
// RL7 - Operation off then on clears cascade latched-off state.
// RL8 - Fault-pin turn-off needs response bit; alert reports input events.
// RL9 - Enabled overvoltage fault pulls auxiliary fault pin low.
// RL10 - Enabled undervoltage fault pulls auxiliary fault pin low.
// RL11 - Tracking channels go down together on any fault or shutdown.
// RL12 - Master configured on after slaves, off before slaves.
// RL13 - Tracking channel goes down on fault, low input, clock low, restore.
// RL14 - Tracking channel masks undervoltage during turn-off delay.
// RL15 - Every channel masks undervoltage during rise and turn-on fault time.
// RL16 - Slave rise and off delay include master delays.
// RL17 - Delay differences exceed setup time and master fall time.
// RL18 - Control input polarity bit chooses low or high start level.
// RL19 - Auxiliary fault held low while any enabled source is active.
module cts_top #(
    parameter int CNT_W = 16,
    parameter int RETRIES = 3
) (
    input wire logic clock, // 200 MHz clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic ce, // Clock enable
    input wire logic reg_we, // Register write strobe
    input wire logic [1:0] reg_addr, // Register index
    input wire logic [15:0] reg_wdata, // Write data
    output logic [15:0] reg_rdata, // Read data
    input wire logic op_on, // Operation command on/off level
    input wire logic restore, // Restore user settings pulse
    input wire logic vin_low, // Input below off threshold
    input wire logic [1:0] ctrl_in, // Control pins
    input wire logic share_clk_in, // Shared clock pin level
    input wire logic fault_line0_n_in, // Fault line pin level
    input wire logic [1:0] ov_fault, // Channel OV fault levels
    input wire logic [1:0] uv_raw, // Channel UV comparator levels
    input wire logic [CNT_W-1:0] ton_delay0, // Channel 0 on delay
    input wire logic [CNT_W-1:0] ton_delay1, // Channel 1 on delay
    input wire logic [CNT_W-1:0] ton_rise0, // Channel 0 rise
    input wire logic [CNT_W-1:0] ton_rise1, // Channel 1 rise
    input wire logic [CNT_W-1:0] toff_delay0, // Channel 0 off delay
    input wire logic [CNT_W-1:0] toff_delay1, // Channel 1 off delay
    output logic [1:0] vout_en, // Converter enables
    output logic [1:0] uv_fault, // Masked UV faults
    output logic aux_fault_oe, // Aux fault pull-down enable
    output logic aux_fault_out, // Aux fault pin driven value
    output logic alert_n, // Alert, active low
    output logic [1:0] fault_line_input_event, // Fault-line event per channel
    output logic trim_gain_hi, // Trim full scale 2.65V when high
    output logic trim_noninv // Non-inverting trim encoding
);
    import cts_pkg::*;
    initial begin
        if (RETRIES < 0 || RETRIES > 7) $error("RETRIES out of range");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] sync1_r, sync2_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_r <= 6'h3F;
            sync2_r <= 6'h3F;
        end else if (ce) begin
            sync1_r <= {ctrl_in, share_clk_in, fault_line0_n_in, ov_fault[0] | ov_fault[1], 1'b1};
            sync2_r <= sync1_r;
        end
    end
    logic [1:0] ov_s1_r, ov_s2_r, uv_s1_r, uv_s2_r;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] trim;
        logic [7:0] oven;
        logic [7:0] uven;
        logic [7:0] chan;
        logic [1:0] evt;
        logic [1:0][2:0] retries;
        logic all_off_seen;
        logic op_d;
    } cts_top_type;
    cts_top_type q_r, q_nxt;
    logic [1:0] ch_latched, ch_umask, ch_fault, start, down, retry_ok;
    logic clear_latch;

    // Fault sources, masked UV during rise or tracking off delay
    assign uv_fault = uv_s2_r & ~ch_umask;
    assign ch_fault = ov_s2_r | uv_fault;

    // Fault-line turn-off, and group turn-off for tracking channels
    logic sys_down, group_fault, fl_down;
    assign fl_down = !sync2_r[2];
    // RL13 tracking down causes
    assign sys_down = vin_low || !sync2_r[3] || restore;
    // RL11 track down together
    assign group_fault = |(ch_fault & {q_r.chan[CTS_TRACK_BIT - 8 + 4], q_r.chan[CTS_TRACK_BIT - 8]});

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            logic pol, casc, trk, ctl;
            assign casc = q_r.chan[CTS_CASCADE_BIT - 8 + 4 * g];
            assign trk = q_r.chan[CTS_TRACK_BIT - 8 + 4 * g];
            assign pol = q_r.chan[CTS_CTRL0_POL_BIT + g];
            // RL18 control polarity
            assign ctl = pol ? sync2_r[4 + g] : !sync2_r[4 + g];
            // RL3 cascade waits control
            assign start[g] = op_on && ctl;
            assign down[g] = (q_r.chan[CTS_FLRESP_BIT - 8 + 4 * g] && fl_down) ||
                (trk && (sys_down || group_fault));
            // RL6 retries despite control
            assign retry_ok[g] = (q_r.retries[g] != 3'(RETRIES)) && (casc || ctl);
            cts_channel #(.CNT_W(CNT_W)) u_ch (
                .clock(clock),
                .rst(rst),
                .ce(ce),
                .start(start[g] || (casc && ctl && op_on)),
                .force_down(down[g]),
                .fault(ch_fault[g]),
                .retry_ok(retry_ok[g]),
                .clear_latch(clear_latch),
                .track_en(trk),
                .ton_delay(g == 0 ? ton_delay0 : ton_delay1),
                .ton_rise(g == 0 ? ton_rise0 : ton_rise1),
                .toff_delay(g == 0 ? toff_delay0 : toff_delay1),
                .enable_out(vout_en[g]),
                .uv_mask(ch_umask[g]),
                .latched(ch_latched[g])
            );
        end
    endgenerate

    // RL7 off-on clears latch
    assign clear_latch = op_on && !q_r.op_d && q_r.all_off_seen;

    // Register writes, retry counts and event flags
    always_comb begin
        q_nxt = q_r;
        q_nxt.op_d = op_on;
        if (!op_on) q_nxt.all_off_seen = 1'b1;
        else if (clear_latch) q_nxt.all_off_seen = 1'b0;
        for (int i = 0; i < 2; i++) begin
            if (clear_latch) q_nxt.retries[i] = '0;
            else if (ch_fault[i] && vout_en[i] && q_r.retries[i] != 3'(RETRIES))
                q_nxt.retries[i] = q_r.retries[i] + 3'h1;
        end
        if (reg_we) begin
            unique case (reg_addr)
                CTS_REG_TRIM: q_nxt.trim = reg_wdata | CTS_TRIM_RST;
                CTS_REG_OVEN: q_nxt.oven = reg_wdata[7:0];
                CTS_REG_UVEN: q_nxt.uven = reg_wdata[7:0];
                CTS_REG_CHAN: begin
                    q_nxt.chan = reg_wdata[7:0];
                    q_nxt.evt = q_r.evt & ~reg_wdata[15:14];
                end
            endcase
        end
        // RL8 fault-line events set
        for (int i = 0; i < 2; i++) begin
            if (fl_down && q_r.chan[CTS_FLRESP_BIT - 8 + 4 * i]) q_nxt.evt[i] = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q_r <= '{trim: CTS_TRIM_RST, oven: CTS_EN_RST, uven: CTS_EN_RST, chan: CTS_CHAN_RST,
                evt: 2'b00, retries: '0, all_off_seen: 1'b0, op_d: 1'b0};
            ov_s1_r <= 2'b00;
            ov_s2_r <= 2'b00;
            uv_s1_r <= 2'b00;
            uv_s2_r <= 2'b00;
        end else if (ce) begin
            q_r <= q_nxt;
            ov_s1_r <= ov_fault;
            ov_s2_r <= ov_s1_r;
            uv_s1_r <= uv_raw;
            uv_s2_r <= uv_s1_r;
        end
    end

    // Read mux
    always_comb begin
        unique case (reg_addr)
            CTS_REG_TRIM: reg_rdata = q_r.trim;
            CTS_REG_OVEN: reg_rdata = {8'h00, q_r.oven};
            CTS_REG_UVEN: reg_rdata = {8'h00, q_r.uven};
            default: reg_rdata = {q_r.evt, 6'h00, q_r.chan};
        endcase
    end

    // RL9 OV pulls aux
    // RL10 UV pulls aux
    // RL19 aux held while active
    assign aux_fault_oe = |((ov_s2_r & q_r.oven[1:0]) | (uv_fault & q_r.uven[1:0]));
    assign aux_fault_out = 1'b0;
    assign alert_n = !(|q_r.evt);
    assign fault_line_input_event = q_r.evt;
    // RL1 gain select
    assign trim_gain_hi = q_r.trim[CTS_TRIM_GAIN_BIT];
    // RL2 polarity select
    assign trim_noninv = q_r.trim[CTS_TRIM_POL_BIT];
endmodule

// ==== cts_top_sva.sv ====
// Port checker for the cascade and tracking sequencer.
// Assumes it is bound to cts_top and sees only its ports.
module cts_top_sva
    import cts_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic rst, // Reset, active high
    input wire logic ce, // Clock enable
    input wire logic reg_we, // Write strobe
    input wire logic [1:0] reg_addr, // Register index
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic [1:0] ov_fault, // OV levels
    input wire logic [1:0] vout_en, // Converter enables
    input wire logic [1:0] uv_fault, // Masked UV
    input wire logic aux_fault_oe, // Aux pull-down
    input wire logic aux_fault_out, // Aux value
    input wire logic alert_n, // Alert
    input wire logic [1:0] fault_line_input_event, // Events
    input wire logic trim_gain_hi, // Gain select
    input wire logic trim_noninv // Trim polarity
);
    logic [1:0] ov_en_r;
    logic [1:0] uv_en_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Shadow the enable registers so relations need no internal taps
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ov_en_r <= 2'h0;
            uv_en_r <= 2'h0;
        end else if (reg_we && ce && reg_addr == CTS_REG_OVEN) begin
            ov_en_r <= reg_wdata[1:0];
        end else if (reg_we && ce && reg_addr == CTS_REG_UVEN) begin
            uv_en_r <= reg_wdata[1:0];
        end
    end
    property p_gain;
        reg_we && ce && reg_addr == CTS_REG_TRIM |=> trim_gain_hi == $past(reg_wdata[1]);
    endproperty
    a_gain: assert property (p_gain) else $error("gain select wrong");
    property p_pol;
        reg_we && ce && reg_addr == CTS_REG_TRIM |=> trim_noninv == $past(reg_wdata[0]);
    endproperty
    a_pol: assert property (p_pol) else $error("trim polarity wrong");
    property p_ov;
        (|(ov_fault & ov_en_r))[*4] |-> aux_fault_oe;
    endproperty
    a_ov: assert property (p_ov) else $error("enabled OV did not pull aux");
    property p_uv;
        (|(uv_fault & uv_en_r))[*2] |-> aux_fault_oe;
    endproperty
    a_uv: assert property (p_uv) else $error("enabled UV did not pull aux");
    property p_rel;
        (!(|(ov_fault & ov_en_r)) && !(|(uv_fault & uv_en_r)))[*5] |-> !aux_fault_oe;
    endproperty
    a_rel: assert property (p_rel) else $error("aux held with no source");
    property p_out;
        aux_fault_oe |-> !aux_fault_out;
    endproperty
    a_out: assert property (p_out) else $error("aux driven high");
    property p_alert;
        |fault_line_input_event |-> ##[0:1] !alert_n;
    endproperty
    a_alert: assert property (p_alert) else $error("event without alert");
    property p_mask;
        $rose(vout_en[0]) |-> (!uv_fault[0])[*4];
    endproperty
    a_mask: assert property (p_mask) else $error("UV seen during rise");
endmodule

bind cts_top cts_top_sva cts_top_sva_inst (.clock, .rst, .ce, .reg_we, .reg_addr, .reg_wdata,
    .ov_fault, .vout_en, .uv_fault, .aux_fault_oe, .aux_fault_out, .alert_n,
    .fault_line_input_event, .trim_gain_hi, .trim_noninv);

// ==== cts_conv_model.sv ====
// Behavioural DC/DC converter: enable in, power-good out.
// Assumes enable comes from the sequencer's clock domain.
module cts_conv_model #(
    parameter int PG_DELAY = 20
) (
    input wire logic clock, // Clock
    input wire logic rst, // Reset, active high
    input wire logic enable, // Converter enable
    output logic pg // Power good, pulled low when off
);
    int cnt;
    // supply power-good chain
    // Good only after a full soft-start, lost on the first clock edge after disable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= 0;
        end else if (!enable) begin
            cnt <= 0;
        end else if (cnt < PG_DELAY) begin
            cnt <= cnt + 1;
        end
    end
    assign pg = (cnt == PG_DELAY);
endmodule

// ==== tb_cts_top.sv ====
// Testbench: registers, aux fault pin, cascade start, fault line.
// Assumes cts_top, cts_conv_model and the checker are compiled first.
module tb_cts_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cts_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic reg_we = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic op_on = 1'b0;
    logic ctrl1_n = 1'b1; // Master control, active low
    logic fl_n = 1'b1;
    logic [1:0] ov = 2'h0;
    logic [1:0] uvr = 2'h0;
    logic [15:0] dly = 16'h0008;
    logic ce = 1'b1;
    logic restore = 1'b0;
    logic vin_low = 1'b0;
    logic share_clk = 1'b1;
    // tracking slave rise spans master delay plus own rise
    logic [15:0] rise0 = 16'h0010;
    // tracking slave off delay spans master off plus own off
    logic [15:0] toff0 = 16'h0010;
    logic [1:0] en, uvf, evt;
    logic [15:0] rdata;
    logic pg1, aux_oe, aux_out, alert_n, gain, noninv;
    int miscompares = 0;
    int checks_done = 0;
    // 200 MHz clock
    always #2.5 clock = ~clock;
    // Channel 0 is the cascade slave, fed by channel 1's power-good
    cts_top #(.CNT_W(16), .RETRIES(3)) cts_top_inst (.clock, .rst, .ce(ce), .reg_we, .reg_addr,
        .reg_wdata, .reg_rdata(rdata), .op_on, .restore(restore), .vin_low(vin_low),
        .ctrl_in({ctrl1_n, pg1}), .share_clk_in(share_clk), .fault_line0_n_in(fl_n), .ov_fault(ov),
        .uv_raw(uvr), .ton_delay0(dly), .ton_delay1(dly), .ton_rise0(rise0), .ton_rise1(dly),
        .toff_delay0(toff0), .toff_delay1(dly), .vout_en(en), .uv_fault(uvf), .aux_fault_oe(aux_oe),
        .aux_fault_out(aux_out), .alert_n, .fault_line_input_event(evt), .trim_gain_hi(gain),
        .trim_noninv(noninv));
    cts_conv_model #(.PG_DELAY(20)) cts_conv_model_inst (.clock, .rst, .enable(en[1]), .pg(pg1));
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(negedge clock);
        reg_we = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_we = 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Bounded wait on an enable, then judge it
    task automatic wait_en(input int i, input logic v);
        int n;
        n = 0;
        while (en[i] !== v && n < 100) begin
            @(negedge clock);
            n++;
        end
        chk("vout_en", {15'h0, v}, {15'h0, en[i]});
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic t_regs;
        chk("trim reset", CTS_TRIM_RST, rdata);
        chk("alert_n", 16'h1, {15'h0, alert_n});
        for (int v = 0; v < 4; v++) begin
            wr(CTS_REG_TRIM, 16'h0008 | 16'(v));
            chk("trim", 16'h0008 | 16'(v), rdata);
            chk("gain pol", 16'(v), {14'h0, gain, noninv});
        end
        // Clock enable low must freeze the registers
        ce = 1'b0;
        wr(CTS_REG_TRIM, 16'h0008);
        chk("trim frozen", 16'h000B, rdata);
        ce = 1'b1;
    endtask
    task automatic t_aux;
        for (int c = 0; c < 2; c++) begin
            for (int e = 0; e < 2; e++) begin
                wr(CTS_REG_OVEN, 16'(e << c));
                ov[c] = 1'b1;
                settle(6);
                chk("aux ov", 16'(e), {15'h0, aux_oe});
                ov[c] = 1'b0;
                settle(6);
                chk("aux idle", 16'h0, {15'h0, aux_oe});
            end
        end
    endtask
    task automatic t_cascade;
        wr(CTS_REG_CHAN, 16'h0015);
        op_on = 1'b1;
        ctrl1_n = 1'b0;
        wait_en(1, 1'b1);
        while (pg1 !== 1'b1) begin
            chk("slave held", 16'h0, {15'h0, en[0]});
            @(negedge clock);
        end
        wait_en(0, 1'b1);
        settle(30);
        wr(CTS_REG_UVEN, 16'h0001);
        uvr[0] = 1'b1;
        settle(6);
        chk("uv fault", 16'h1, {15'h0, uvf[0]});
        chk("aux uv", 16'h1, {15'h0, aux_oe});
        uvr[0] = 1'b0;
        wr(CTS_REG_UVEN, 16'h0000);
        op_on = 1'b0;
        wait_en(0, 1'b0);
        wait_en(1, 1'b0);
        op_on = 1'b1;
        wait_en(0, 1'b1);
        op_on = 1'b0;
        wait_en(0, 1'b0);
    endtask
    task automatic t_fline;
        fl_n = 1'b0;
        settle(6);
        fl_n = 1'b1;
        // Let the released pin pass the synchroniser so the clear is not beaten by a set
        settle(3);
        chk("event", 16'h1, {15'h0, evt[0]});
        chk("alert_n", 16'h0, {15'h0, alert_n});
        wr(CTS_REG_CHAN, 16'hC015);
        wr(CTS_REG_CHAN, 16'h0015);
        chk("alert_n clr", 16'h1, {15'h0, alert_n});
    endtask
    // Channel 0 tracks; every system down cause must bring it down
    task automatic t_track;
        // master channel 1 is not tracking, slave rise and off delay are longer
        wr(CTS_REG_CHAN, 16'h0012);
        op_on = 1'b1;
        ctrl1_n = 1'b0;
        wait_en(0, 1'b1);
        vin_low = 1'b1;
        wait_en(0, 1'b0);
        vin_low = 1'b0;
        wait_en(0, 1'b1);
        share_clk = 1'b0;
        wait_en(0, 1'b0);
        share_clk = 1'b1;
        wait_en(0, 1'b1);
        @(negedge clock);
        restore = 1'b1;
        @(negedge clock);
        restore = 1'b0;
        wait_en(0, 1'b0);
        wait_en(0, 1'b1);
        op_on = 1'b0;
        wait_en(0, 1'b0);
        wait_en(1, 1'b0);
    endtask
    // Main sequence: reset for 8 cycles, then the scenarios
    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        settle(2);
        t_regs;
        t_aux;
        t_cascade;
        t_fline;
        t_track;
        test_done;
    end
    // Watchdog at 4000 cycles, well beyond the few hundred cycles the run needs
    initial begin
        #20000;
        miscompares++;
        test_done;
    end
endmodule
